// ==== verilog/opfd_defines.svh ====
// Constants of the opcode field decoder: bus offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from every file that needs them.
`ifndef OPFD_DEFINES_SVH
`define OPFD_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------
`define OPFD_OFS_BANK     8'h00
`define OPFD_OFS_PROGRAM_TABLE_POINTER   8'h04
`define OPFD_OFS_TBLLAT   8'h08
`define OPFD_OFS_STATUS   8'h0C
`define OPFD_OFS_PTR0     8'h10
`define OPFD_OFS_PTR_LAST 8'h1C

// ----------------------------------------------------------------------
// Instruction field positions
// ----------------------------------------------------------------------
`define OPFD_D_POS        9
`define OPFD_A_POS        8
`define OPFD_S_CALL_POS   8
`define OPFD_S_RET_POS    0
`define OPFD_W2_TAG       4'hF
`define OPFD_IDX_PTR      2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OPFD_RST_BANK     4'h0
`define OPFD_RST_PROGRAM_TABLE_POINTER   21'h000000
`define OPFD_RST_TBLLAT   8'h00
`define OPFD_RST_PTR      12'h000

// ----------------------------------------------------------------------
// Timing: clock periods in one instruction cycle
// ----------------------------------------------------------------------
`define OPFD_OSC_PER_CYC  3'h4

`endif

// ==== verilog/opfd_pkg.sv ====
// Types of the opcode field decoder.
// Assumes opfd_defines.svh for all numeric constants.
package opfd_pkg;

  // Operand format of a first word, classified by the fetch unit
  typedef enum logic [3:0] {
    OPFD_FMT_NONE,    // No operands
    OPFD_FMT_BYTE,    // f, d, a
    OPFD_FMT_BIT,     // f, b, a
    OPFD_FMT_LIT,     // 8-bit literal
    OPFD_FMT_LITPTR,  // Pointer selector in the file field
    OPFD_FMT_MOVE,    // Two-word register to register move
    OPFD_FMT_ABS,     // Two-word jump or call, 20-bit target
    OPFD_FMT_BRA,     // 11-bit relative branch
    OPFD_FMT_BCOND,   // 8-bit conditional relative branch
    OPFD_FMT_RET,     // Return with fast bit
    OPFD_FMT_TBLRD,   // Table read
    OPFD_FMT_TBLWT,   // Table write
    OPFD_FMT_IDX      // Two-word indexed move
  } opfd_fmt_e;

  // Table pointer behaviour
  typedef enum logic [1:0] {
    OPFD_TBL_KEEP,
    OPFD_TBL_POSTINC,
    OPFD_TBL_POSTDEC,
    OPFD_TBL_PREINC
  } opfd_tbl_e;

  // Word assembly state
  typedef enum logic {
    OPFD_ST_IDLE,
    OPFD_ST_HOLD
  } opfd_st_e;

endpackage

// ==== verilog/opfd_tbl_if.sv ====
// Link between the decoder core and its table pointer unit.
// Assumes both ends run on the same clock; the unit is combinational.
`timescale 1ns/1ns
interface opfd_tbl_if;
  import opfd_pkg::*;
  opfd_tbl_e   mode;       // Pointer behaviour of this transfer
  logic [20:0] ptr;        // Current table pointer
  logic [20:0] acc_addr;   // Program memory address used
  logic [20:0] next_ptr;   // Pointer after the transfer

  modport core (output mode, output ptr, input acc_addr, input next_ptr);
  modport unit (input mode, input ptr, output acc_addr, output next_ptr);
endinterface

// ==== verilog/opfd_phase.sv ====
// Instruction cycle timer: marks the last of four clock periods.
// Assumes ref_clk is the oscillator of the core.
`timescale 1ns/1ns
`include "opfd_defines.svh"
module opfd_phase (
  input  wire logic ref_clk,
  input  wire logic rst,
  output logic      cycle_end
);
  logic [2:0] cnt_q;  // Period within the instruction cycle

  // ----------------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------------
  // Wraps after four periods
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
    end else if (cycle_end) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Last period of the cycle
  assign cycle_end = (cnt_q == (`OPFD_OSC_PER_CYC - 3'h1));
endmodule

// ==== verilog/opfd_program_table_pointer.sv ====
// Table pointer unit: access address and updated pointer per mode.
// Assumes the core registers the pointer and applies next_ptr.
`timescale 1ns/1ns
module opfd_program_table_pointer (
  opfd_tbl_if.unit tbl
);
  import opfd_pkg::*;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  // Pre-increment uses the bumped pointer; the post forms use the old one
  always_comb begin
    tbl.acc_addr = tbl.ptr;
    tbl.next_ptr = tbl.ptr;
    case (tbl.mode)
      OPFD_TBL_KEEP: begin
        tbl.next_ptr = tbl.ptr;
      end
      OPFD_TBL_POSTINC: begin
        tbl.next_ptr = tbl.ptr + 21'h000001;
      end
      OPFD_TBL_POSTDEC: begin
        tbl.next_ptr = tbl.ptr - 21'h000001;
      end
      OPFD_TBL_PREINC: begin
        tbl.next_ptr = tbl.ptr + 21'h000001;
        tbl.acc_addr = tbl.ptr + 21'h000001;
      end
      default: begin
        tbl.next_ptr = tbl.ptr;
      end
    endcase
  end
endmodule

// ==== verilog/opfd_top.sv ====
// Opcode field decoder: splits 16/32-bit instruction words into operand
// fields for the datapath, with an AHB-Lite register port.
// Assumes the fetch unit classifies each first word by operand format
// and holds instr_valid until instr_ready; all inputs share ref_clk.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "opfd_defines.svh"
module opfd_top
  import opfd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Instruction words from fetch
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire opfd_fmt_e   instr_fmt,
  output logic             instr_ready,
  // Table memory port
  input  wire logic        tbl_rvalid,
  input  wire logic [7:0]  tbl_rdata,
  output logic             tbl_req,
  output logic             tbl_write,
  output logic [20:0]      tbl_addr,
  output logic [7:0]       tbl_wdata,
  // Decoded fields to the datapath
  output logic             dec_valid,
  output opfd_fmt_e        dec_fmt,
  output logic             dec_nop,
  output logic             access_ram,
  output logic [11:0]      file_addr,
  output logic             dest_to_file,
  output logic [2:0]       bit_sel,
  output logic [1:0]       ptr_sel,
  output logic [19:0]      literal,
  output logic [11:0]      src_addr,
  output logic [11:0]      dst_addr,
  output logic [20:0]      target_addr,
  output logic [20:0]      rel_offset,
  output logic             fast_shadow
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Sign extension of a branch offset to program counter width
  function automatic logic [20:0] sext(input logic [10:0] v, input logic wide);
    logic [20:0] r;
    r = wide ? {{10{v[10]}}, v} : {{13{v[7]}}, v[7:0]};
    return r;
  endfunction

  // Second word carries its tag nibble
  function automatic logic is_w2(input logic [15:0] w);
    return w[15:12] == `OPFD_W2_TAG;
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic        cycle_end;        // Last period of instruction cycle
  logic        take;             // Word accepted this cycle
  logic        fire;             // Complete instruction decoded
  logic        pair_bad;         // Held word met a non-tagged word
  opfd_st_e    st_q;             // Word assembly state
  logic [15:0] w1_q;             // Held first word
  opfd_fmt_e   f1_q;             // Held format
  logic [15:0] fw;               // First word in decode
  logic [15:0] sw;               // Second word in decode
  opfd_fmt_e   ff;               // Format in decode
  logic [3:0]  bank_q;           // Bank select register
  logic [20:0] program_table_pointer_q;         // Program table pointer
  logic [7:0]  tbllat_q;         // Table byte latch
  logic [11:0] ptr_q [4];        // Indirect pointer registers
  logic        pair_err_q;       // Sticky bad pair flag
  logic        orphan_q;         // Sticky lone second word flag
  logic        ap_valid_q;       // Bus data phase pending
  logic        ap_write_q;       // Pending access is a write
  logic [7:0]  ap_addr_q;        // Pending byte offset
  logic        ap_take;          // Address phase taken
  logic [31:0] rd_d;             // Read data for the next data phase
  logic        sw_bank;          // Software writes bank register
  logic        sw_program_table_pointer;        // Software writes table pointer
  logic        sw_tbllat;        // Software writes table latch
  logic        sw_status;        // Software writes status
  logic        tbl_go;           // Table transfer decoded
  opfd_tbl_if  tbl ();           // Table pointer unit link

  // ----------------------------------------------------------------------
  // Instruction cycle and table pointer units
  // ----------------------------------------------------------------------
  opfd_phase u_phase (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cycle_end (cycle_end)
  );

  opfd_program_table_pointer u_program_table_pointer (
    .tbl (tbl.unit)
  );

  assign tbl.ptr  = program_table_pointer_q;
  assign tbl.mode = opfd_tbl_e'(fw[1:0]);

  // ----------------------------------------------------------------------
  // Word acceptance and assembly
  // ----------------------------------------------------------------------
  assign instr_ready = cycle_end;
  assign take        = instr_valid && cycle_end;
  assign pair_bad    = take && (st_q == OPFD_ST_HOLD) && !is_w2(instr_word);
  assign fire = take && (((st_q == OPFD_ST_HOLD) && is_w2(instr_word)) ||
                         ((st_q == OPFD_ST_IDLE) && !is_w2(instr_word) &&
                          (instr_fmt != OPFD_FMT_MOVE) &&
                          (instr_fmt != OPFD_FMT_ABS) &&
                          (instr_fmt != OPFD_FMT_IDX)));

  // Holds a two-word first word until the next word is taken, tagged or not
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= OPFD_ST_IDLE;
      w1_q <= 16'h0000;
      f1_q <= OPFD_FMT_NONE;
    end else if (take) begin
      if (st_q == OPFD_ST_HOLD) begin
        st_q <= OPFD_ST_IDLE;
      end else if (!is_w2(instr_word) && ((instr_fmt == OPFD_FMT_MOVE) ||
                   (instr_fmt == OPFD_FMT_ABS) || (instr_fmt == OPFD_FMT_IDX))) begin
        st_q <= OPFD_ST_HOLD;
        w1_q <= instr_word;
        f1_q <= instr_fmt;
      end
    end
  end

  // Words in decode: held pair, or a single word with no second word
  always_comb begin
    if (st_q == OPFD_ST_HOLD) begin
      fw = w1_q;
      sw = instr_word;
      ff = f1_q;
    end else begin
      fw = instr_word;
      sw = 16'h0000;
      ff = instr_fmt;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded field registers
  // ----------------------------------------------------------------------
  // Shared fields load from the first word for every format; the case adds each format's own
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dec_fmt      <= OPFD_FMT_NONE;
      access_ram   <= 1'b0;
      file_addr    <= 12'h000;
      dest_to_file <= 1'b0;
      bit_sel      <= 3'h0;
      ptr_sel      <= 2'h0;
      literal      <= 20'h00000;
      src_addr     <= 12'h000;
      dst_addr     <= 12'h000;
      target_addr  <= 21'h000000;
      rel_offset   <= 21'h000000;
      fast_shadow  <= 1'b0;
    end else if (fire) begin
      dec_fmt      <= ff;
      access_ram   <= !fw[`OPFD_A_POS];
      // Bank register ignored for access RAM
      file_addr    <= fw[`OPFD_A_POS] ? {bank_q, fw[7:0]} : {4'h0, fw[7:0]};
      dest_to_file <= fw[`OPFD_D_POS] && (ff == OPFD_FMT_BYTE);
      bit_sel      <= fw[11:9];
      ptr_sel      <= fw[1:0];
      fast_shadow  <= 1'b0;
      literal      <= {12'h000, fw[7:0]};
      src_addr     <= 12'h000;
      dst_addr     <= 12'h000;
      rel_offset   <= 21'h000000;
      target_addr  <= 21'h000000;
      case (ff)
        OPFD_FMT_MOVE: begin
          src_addr <= fw[11:0];
          dst_addr <= sw[11:0];
          literal  <= {8'h00, sw[11:0]};
        end
        OPFD_FMT_ABS: begin
          target_addr <= {1'b0, sw[11:0], fw[7:0]};
          literal     <= {sw[11:0], fw[7:0]};
          fast_shadow <= fw[`OPFD_S_CALL_POS];
        end
        OPFD_FMT_RET: begin
          fast_shadow <= fw[`OPFD_S_RET_POS];
        end
        OPFD_FMT_BRA: begin
          rel_offset <= sext(fw[10:0], 1'b1);
        end
        OPFD_FMT_BCOND: begin
          rel_offset <= sext(fw[10:0], 1'b0);
        end
        OPFD_FMT_IDX: begin
          // Offsets from both words added to the indexing pointer
          src_addr <= ptr_q[`OPFD_IDX_PTR] + {5'h00, fw[6:0]};
          dst_addr <= ptr_q[`OPFD_IDX_PTR] + {5'h00, sw[6:0]};
        end
        default: begin
          rel_offset <= 21'h000000;
        end
      endcase
    end
  end

  // Strobes: full decode, or a lone second word run as no-operation
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
      dec_nop   <= 1'b0;
    end else begin
      dec_valid <= fire || (take && (st_q == OPFD_ST_IDLE) && is_w2(instr_word));
      dec_nop   <= take && (st_q == OPFD_ST_IDLE) && is_w2(instr_word);
    end
  end

  // ----------------------------------------------------------------------
  // Table transfers
  // ----------------------------------------------------------------------
  assign tbl_go = fire && ((ff == OPFD_FMT_TBLRD) || (ff == OPFD_FMT_TBLWT));

  // Request to program memory with latch data for writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tbl_req   <= 1'b0;
      tbl_write <= 1'b0;
      tbl_addr  <= `OPFD_RST_PROGRAM_TABLE_POINTER;
      tbl_wdata <= `OPFD_RST_TBLLAT;
    end else begin
      tbl_req <= tbl_go;
      if (tbl_go) begin
        tbl_write <= (ff == OPFD_FMT_TBLWT);
        tbl_addr  <= tbl.acc_addr;
        tbl_wdata <= tbllat_q;
      end
    end
  end

  // Table pointer: a software write wins over a hardware update
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      program_table_pointer_q <= `OPFD_RST_PROGRAM_TABLE_POINTER;
    end else if (sw_program_table_pointer) begin
      program_table_pointer_q <= hwdata[20:0];
    end else if (tbl_go) begin
      program_table_pointer_q <= tbl.next_ptr;
    end
  end

  // Table latch: memory read data wins over a software write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tbllat_q <= `OPFD_RST_TBLLAT;
    end else if (tbl_rvalid) begin
      tbllat_q <= tbl_rdata;
    end else if (sw_tbllat) begin
      tbllat_q <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_take   = hsel && htrans[1] && hready;
  assign sw_bank   = ap_valid_q && ap_write_q && (ap_addr_q == `OPFD_OFS_BANK);
  assign sw_program_table_pointer = ap_valid_q && ap_write_q && (ap_addr_q == `OPFD_OFS_PROGRAM_TABLE_POINTER);
  assign sw_tbllat = ap_valid_q && ap_write_q && (ap_addr_q == `OPFD_OFS_TBLLAT);
  assign sw_status = ap_valid_q && ap_write_q && (ap_addr_q == `OPFD_OFS_STATUS);

  // Address phase capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 8'h00;
    end else begin
      ap_valid_q <= ap_take;
      if (ap_take) begin
        ap_write_q <= hwrite;
        ap_addr_q  <= {haddr[7:2], 2'h0};
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_d = 32'h00000000;
    case ({haddr[7:2], 2'h0})
      `OPFD_OFS_BANK:   rd_d = {28'h0000000, bank_q};
      `OPFD_OFS_PROGRAM_TABLE_POINTER: rd_d = {11'h000, program_table_pointer_q};
      `OPFD_OFS_TBLLAT: rd_d = {24'h000000, tbllat_q};
      `OPFD_OFS_STATUS: rd_d = {29'h00000000, orphan_q, pair_err_q, st_q == OPFD_ST_HOLD};
      default: begin
        if (haddr[7:0] >= `OPFD_OFS_PTR0 && haddr[7:0] <= `OPFD_OFS_PTR_LAST) begin
          rd_d = {20'h00000, ptr_q[haddr[3:2]]};
        end
      end
    endcase
  end

  // Read data registered for the data phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // Bank select register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bank_q <= `OPFD_RST_BANK;
    end else if (sw_bank) begin
      bank_q <= hwdata[3:0];
    end
  end

  // Indirect pointer registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        ptr_q[i] <= `OPFD_RST_PTR;
      end
    end else if (ap_valid_q && ap_write_q && ap_addr_q >= `OPFD_OFS_PTR0 &&
                 ap_addr_q <= `OPFD_OFS_PTR_LAST) begin
      ptr_q[ap_addr_q[3:2]] <= hwdata[11:0];
    end
  end

  // Sticky flags: write one to clear, a new event wins over the clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pair_err_q <= 1'b0;
      orphan_q   <= 1'b0;
    end else begin
      pair_err_q <= pair_bad || (pair_err_q && !(sw_status && hwdata[1]));
      orphan_q   <= (take && (st_q == OPFD_ST_IDLE) && is_w2(instr_word)) ||
                    (orphan_q && !(sw_status && hwdata[2]));
    end
  end
endmodule

// ==== tb/opfd_sva.sv ====
// Port-level properties of the opcode field decoder.
// Assumes it is bound onto opfd_top and sees only its ports.
`timescale 1ns/1ns
module opfd_sva
  import opfd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        instr_ready,
  input wire logic        tbl_req,
  input wire logic        dec_valid,
  input wire logic        dec_nop,
  input wire opfd_fmt_e   dec_fmt,
  input wire logic        access_ram,
  input wire logic [11:0] file_addr,
  input wire logic [11:0] dst_addr,
  input wire logic [19:0] literal
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_RDY: assert property (instr_ready |=> !instr_ready [*3] ##1 instr_ready)
    else $error("instr_ready not one in four");
  AST_TAKE: assert property (dec_valid |-> $past(instr_valid && instr_ready))
    else $error("decode without a taken word");
  AST_PULSE: assert property (dec_valid |=> !dec_valid ##1 !dec_valid)
    else $error("dec_valid longer than one cycle");
  AST_HOLD: assert property (!dec_valid || dec_nop |-> $stable({file_addr, dst_addr, literal}))
    else $error("fields moved without a decode");
  AST_NOP: assert property (dec_nop |-> dec_valid && $past(instr_word[15:12]) == 4'hF)
    else $error("nop without a lone second word");
  AST_MOVE: assert property (dec_valid && !dec_nop && dec_fmt == OPFD_FMT_MOVE |->
    $past(instr_word[15:12]) == 4'hF && dst_addr == $past(instr_word[11:0]))
    else $error("move second word wrong");
  AST_TBL: assert property (tbl_req |-> dec_valid && dec_fmt inside {OPFD_FMT_TBLRD, OPFD_FMT_TBLWT})
    else $error("table request without table decode");
  AST_BYTE: assert property (dec_valid && dec_fmt == OPFD_FMT_BYTE && access_ram |->
    file_addr[11:8] == 4'h0)
    else $error("access RAM address has bank bits");
  AST_LIT: assert property (dec_valid && dec_fmt == OPFD_FMT_LIT |->
    literal == {12'h000, $past(instr_word[7:0])})
    else $error("literal not low byte");
  CV_ABS: cover property (dec_valid && dec_fmt == OPFD_FMT_ABS);
  CV_NOP: cover property (dec_nop);
  CV_TBL: cover property (tbl_req);
endmodule
bind opfd_top opfd_sva u_sva (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready), .tbl_req(tbl_req), .dec_valid(dec_valid),
  .dec_nop(dec_nop), .dec_fmt(dec_fmt), .access_ram(access_ram), .file_addr(file_addr),
  .dst_addr(dst_addr), .literal(literal));

// ==== tb/opfd_fetch_model.sv ====
// Fetch unit and table memory seen from the decoder.
// Assumes go pulses for one cycle while instr_valid is low.
`timescale 1ns/1ns
module opfd_fetch_model
  import opfd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [15:0] word,
  input  wire opfd_fmt_e   fmt,
  input  wire logic        instr_ready,
  output logic             instr_valid,
  output logic [15:0]      instr_word,
  output opfd_fmt_e        instr_fmt,
  input  wire logic        tbl_req,
  input  wire logic        tbl_write,
  input  wire logic [20:0] tbl_addr,
  output logic             tbl_rvalid,
  output logic [7:0]       tbl_rdata
);
  initial {instr_valid, instr_word, tbl_rvalid, tbl_rdata} = '0;
  initial instr_fmt = OPFD_FMT_NONE;
  // Offer a word and hold it until taken; scramble it once released
  always @(posedge ref_clk) begin
    if (go) begin
      instr_valid <= 1'b1;
      instr_word  <= word;
      instr_fmt   <= fmt;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
      instr_word  <= ~instr_word;
    end
  end
  // Memory byte one cycle after a read request
  always @(posedge ref_clk) begin
    tbl_rvalid <= tbl_req && !tbl_write;
    tbl_rdata  <= (tbl_req && !tbl_write) ? tbl_addr[7:0] + 8'h11 : ~tbl_rdata;
  end
endmodule

// ==== tb/opcode_field_decoder_bench.sv ====
// Bench: AHB-Lite register access and instruction decode sequences.
// Assumes opfd_top with zero-wait bus and the fetch model beside it.
`timescale 1ns/1ns
`include "opfd_defines.svh"
module opcode_field_decoder_bench
  import opfd_pkg::*;
;
  logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, go, tbl_req, tbl_write, tbl_rvalid;
  logic instr_valid, instr_ready, dec_valid, dec_nop, access_ram, dest_to_file, fast_shadow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, ptr_sel;
  logic [15:0] word, instr_word;
  logic [20:0] tbl_addr, target_addr, rel_offset, p, e;
  logic [11:0] file_addr, src_addr, dst_addr;
  logic [19:0] literal;
  logic [7:0]  tbl_rdata, tbl_wdata;
  logic [2:0]  bit_sel;
  opfd_fmt_e   fmt, instr_fmt, dec_fmt;
  int          num_errors = 0, checks = 0, m;
  int          m_list[4] = '{1, 3, 2, 0};
  opfd_top dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .instr_valid, .instr_word,
    .instr_fmt, .instr_ready, .tbl_rvalid, .tbl_rdata, .tbl_req, .tbl_write, .tbl_addr,
    .tbl_wdata, .dec_valid, .dec_fmt, .dec_nop, .access_ram, .file_addr, .dest_to_file,
    .bit_sel, .ptr_sel, .literal, .src_addr, .dst_addr, .target_addr, .rel_offset, .fast_shadow);
  opfd_fetch_model u_fetch (.ref_clk, .go, .word, .fmt, .instr_ready, .instr_valid,
    .instr_word, .instr_fmt, .tbl_req, .tbl_write, .tbl_addr, .tbl_rvalid, .tbl_rdata);
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  // One AHB-Lite single transfer; read data taken at the data-phase end
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
    do @(posedge ref_clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (!hreadyout);
    rd = hrdata;
  endtask
  // Hand a word to fetch; with last set wait for the decode pulse
  task send(input logic [15:0] w, input opfd_fmt_e f, input logic last);
    do @(posedge ref_clk); while (instr_valid || go);
    go   <= 1'b1;
    word <= w;
    fmt  <= f;
    @(posedge ref_clk) go <= 1'b0;
    if (last) begin
      for (int i = 0; i < 40 && dec_valid !== 1'b1; i++) @(negedge ref_clk);
      chk("dec_valid", 1, dec_valid);
    end
  endtask
  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, go, word} = {1'b1, 85'h0};
    fmt = OPFD_FMT_NONE;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1, `OPFD_OFS_BANK, 32'h5); bus(0, `OPFD_OFS_BANK, 0); chk("bank", 5, rd);
    bus(0, 32'h40, 0); chk("unmapped", 0, rd); chk("hresp", 0, hresp);
    bus(1, `OPFD_OFS_PTR0 + 8'h08, 32'h120); bus(0, `OPFD_OFS_PTR0 + 8'h08, 0);
    chk("ptr2", 32'h120, rd);
    $display("registers done");
    send(16'h0334, OPFD_FMT_BYTE, 1); chk("bank addr", 12'h534, file_addr);
    chk("dest file", 1, dest_to_file); chk("ram a1", 0, access_ram);
    send(16'h00FF, OPFD_FMT_BYTE, 1); chk("access addr", 12'h0FF, file_addr);
    chk("dest acc", 0, dest_to_file); chk("ram a0", 1, access_ram);
    send(16'h8A00, OPFD_FMT_BIT, 1); chk("bit", 5, bit_sel);
    send(16'h0E7F, OPFD_FMT_LIT, 1); chk("literal", 20'h0007F, literal);
    send(16'h0EE3, OPFD_FMT_LITPTR, 1); chk("ptr sel", 3, ptr_sel);
    send(16'hD400, OPFD_FMT_BRA, 1); chk("bra", 21'h1FFC00, rel_offset);
    send(16'hE280, OPFD_FMT_BCOND, 1); chk("bcond", 21'h1FFF80, rel_offset);
    send(16'hED12, OPFD_FMT_ABS, 0); send(16'hF345, OPFD_FMT_NONE, 1);
    chk("target", 20'h34512, target_addr[19:0]); chk("fast abs", 1, fast_shadow);
    send(16'hCFFF, OPFD_FMT_MOVE, 0); send(16'hF5A6, OPFD_FMT_NONE, 1);
    chk("src", 12'hFFF, src_addr); chk("dst", 12'h5A6, dst_addr);
    send(16'hE805, OPFD_FMT_IDX, 0); send(16'hF00A, OPFD_FMT_NONE, 1);
    chk("idx src", 12'h125, src_addr); chk("idx dst", 12'h12A, dst_addr);
    send(16'h0013, OPFD_FMT_RET, 1); chk("fast ret", 1, fast_shadow);
    send(16'h0012, OPFD_FMT_RET, 1); chk("slow ret", 0, fast_shadow);
    send(16'hF123, OPFD_FMT_NONE, 1); chk("nop", 1, dec_nop);
    bus(0, `OPFD_OFS_STATUS, 0); chk("orphan", 32'h4, rd);
    bus(1, `OPFD_OFS_STATUS, 32'h4); bus(0, `OPFD_OFS_STATUS, 0);
    chk("orphan clr", 0, rd);
    $display("decode done");
    p = 21'h100000;
    bus(1, `OPFD_OFS_PROGRAM_TABLE_POINTER, p);
    foreach (m_list[k]) begin
      m = m_list[k];
      e = (m == 3) ? p + 21'h000001 : p;
      p = (m == 1 || m == 3) ? p + 21'h000001 : (m == 2) ? p - 21'h000001 : p;
      send(16'h0008 | 16'(m), OPFD_FMT_TBLRD, 1); chk("tbl addr", e, tbl_addr);
      bus(0, `OPFD_OFS_PROGRAM_TABLE_POINTER, 0); chk("tbl ptr", p, rd);
    end
    bus(0, `OPFD_OFS_TBLLAT, 0); chk("latch", e[7:0] + 8'h11, rd);
    send(16'h000C, OPFD_FMT_TBLWT, 1); chk("tbl wdata", e[7:0] + 8'h11, tbl_wdata);
    chk("tbl write", 1, tbl_write); chk("tbl fmt", OPFD_FMT_TBLWT, dec_fmt);
    chk("tbl keep", p, tbl_addr);
    $display("table done");
    test_done();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end
endmodule
